/* design/psir_pkg.sv */
// Shared constants and types plus the input synchroniser module
package psir_pkg;
    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int SLOTS      = 6;
    localparam int PAIRS      = 5;
    localparam int PINS       = 4;
    localparam int LINES      = 8;
    localparam int AD_BITS    = 7;
    localparam int STRAP_BITS = 9;
    localparam int SYNC_BITS  = STRAP_BITS + AD_BITS + LINES + 2 * PAIRS + PINS * SLOTS;

    // ------------------------------------------------------------
    // Board line numbers, A to H
    // ------------------------------------------------------------
    localparam logic [2:0] LINE_A = 3'h0;
    localparam logic [2:0] LINE_B = 3'h1;
    localparam logic [2:0] LINE_C = 3'h2;
    localparam logic [2:0] LINE_D = 3'h3;
    localparam logic [2:0] LINE_E = 3'h4;
    localparam logic [2:0] LINE_F = 3'h5;
    localparam logic [2:0] LINE_G = 3'h6;
    localparam logic [2:0] LINE_H = 3'h7;

    // ------------------------------------------------------------
    // Routing per slot, pin D down to pin A; slot 5 is the riser top slot
    // ------------------------------------------------------------
    localparam logic [3:0][2:0] ROUTE_S0    = {LINE_D, LINE_C, LINE_B, LINE_A};
    localparam logic [3:0][2:0] ROUTE_S1    = {LINE_H, LINE_G, LINE_F, LINE_E};
    localparam logic [3:0][2:0] ROUTE_S2    = {LINE_A, LINE_B, LINE_D, LINE_C};
    localparam logic [3:0][2:0] ROUTE_S3    = {LINE_G, LINE_F, LINE_C, LINE_D};
    localparam logic [3:0][2:0] ROUTE_S4    = {LINE_E, LINE_H, LINE_G, LINE_F};
    localparam logic [3:0][2:0] ROUTE_RISER = {LINE_E, LINE_H, LINE_G, LINE_F};
    localparam logic [5:0][3:0][2:0] SLOT_ROUTE =
        {ROUTE_RISER, ROUTE_S4, ROUTE_S3, ROUTE_S2, ROUTE_S1, ROUTE_S0};

    // ------------------------------------------------------------
    // Select address line per slot
    // ------------------------------------------------------------
    localparam logic [4:0] AD_LOW = 5'h10;
    localparam logic [5:0][4:0] SLOT_IDSEL_AD =
        {5'h16, 5'h14, 5'h13, 5'h12, 5'h11, 5'h10};

    // ------------------------------------------------------------
    // Build straps and timing
    // ------------------------------------------------------------
    localparam logic [1:0] BUILD_SEL_ONE  = 2'h0;
    localparam logic [1:0] BUILD_SEL_TWO  = 2'h1;
    localparam logic [1:0] BUILD_SEL_FIVE = 2'h2;
    localparam logic [1:0] STRAP_SETTLE   = 2'h3;

    typedef enum logic [2:0] {
        BUILD_ONE  = 3'h1,
        BUILD_TWO  = 3'h2,
        BUILD_FIVE = 3'h4
    } psir_build_t;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [SYNC_BITS-1:0] SYNC_RST =
        {9'h000, 7'h00, 8'hFF, 5'h1F, 5'h1F, 24'hFFFFFF};
endpackage

// Two-stage synchroniser; the first stage feeds only the second
module psir_sync #(
    parameter int                WIDTH   = 1,
    parameter logic [WIDTH-1:0]  RST_VAL = '0
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             arst_b,
    // Data
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } psir_sync_t;

    psir_sync_t sync_reg;
    psir_sync_t sync_next;

    always_comb begin
        sync_next.meta   = d;
        sync_next.stable = sync_reg.meta;
    end

    always_ff @(posedge clk or negedge arst_b) begin
        if (!arst_b) begin
            sync_reg <= {RST_VAL, RST_VAL};
        end else begin
            sync_reg <= sync_next;
        end
    end

    assign q = sync_reg.stable;
endmodule

/* design/psir_top.sv */
// Slot interrupt, select and request/grant routing for the board builds

// Notes on behaviour
// - Interrupt lines are active-low open-drain levels so many sources can share one line.
// - Interrupt pins are asynchronous and pass two flip-flops before any logic uses them.
// - A board line stays asserted exactly as long as a routed source holds its pin low.
// - A single-function card uses only its first pin; a slot carries at most four pins.
// - Pins B to D of a single-function card are ignored and give no request.
// - Slot 0 uses pair 0, select AD16 and lines A, B, C, D.
// - Slot 1 exists in two- and five-slot builds, uses pair 1, AD17 and lines E to H.
// - Slot 2 of the five-slot build uses pair 2, AD18 and lines C, D, B, A.
// - Slot 3 of the five-slot build uses pair 3, AD19 and lines D, C, F, G.
// - Slot 4 of the five-slot build uses pair 4, AD20 and lines F, G, H, E.
// - With the riser in slot 0 the lower slot passes through and the top slot uses AD22 and F, G, H, E.
module psir_top (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_b,
    // Build straps
    input  wire logic [1:0]  build_sel,
    input  wire logic        riser_fitted,
    input  wire logic [5:0]  slot_multi_fn,
    // Slot interrupt pins, D down to A
    input  wire logic [3:0]  slot0_int_n,
    input  wire logic [3:0]  slot1_int_n,
    input  wire logic [3:0]  slot2_int_n,
    input  wire logic [3:0]  slot3_int_n,
    input  wire logic [3:0]  slot4_int_n,
    input  wire logic [3:0]  riser_int_n,
    // Request and grant
    input  wire logic [4:0]  slot_req_n,
    output logic      [4:0]  arb_req_n,
    input  wire logic [4:0]  arb_gnt_n,
    output logic      [4:0]  slot_gnt_n,
    // Select address lines AD22 down to AD16
    input  wire logic [6:0]  cfg_ad_hi,
    output logic      [5:0]  slot_idsel,
    // Board interrupt lines, open drain
    input  wire logic        board_irq_line_a_i,
    output logic             board_irq_line_a_o,
    output logic             board_irq_line_a_oe,
    input  wire logic        board_irq_line_b_i,
    output logic             board_irq_line_b_o,
    output logic             board_irq_line_b_oe,
    input  wire logic        board_irq_line_c_i,
    output logic             board_irq_line_c_o,
    output logic             board_irq_line_c_oe,
    input  wire logic        board_irq_line_d_i,
    output logic             board_irq_line_d_o,
    output logic             board_irq_line_d_oe,
    input  wire logic        board_irq_line_e_i,
    output logic             board_irq_line_e_o,
    output logic             board_irq_line_e_oe,
    input  wire logic        board_irq_line_f_i,
    output logic             board_irq_line_f_o,
    output logic             board_irq_line_f_oe,
    input  wire logic        board_irq_line_g_i,
    output logic             board_irq_line_g_o,
    output logic             board_irq_line_g_oe,
    input  wire logic        board_irq_line_h_i,
    output logic             board_irq_line_h_o,
    output logic             board_irq_line_h_oe,
    // Line levels as seen on the wire
    output logic      [7:0]  board_irq_level_n
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        psir_pkg::psir_build_t build;
        logic                  riser;
        logic [5:0]            multi_fn;
        logic [1:0]            strap_cnt;
        logic                  strap_done;
        logic [7:0]            line_o;
        logic [7:0]            line_oe;
        logic [7:0]            level_n;
        logic [4:0]            req_n;
        logic [4:0]            gnt_n;
        logic [5:0]            idsel;
    } psir_state_t;

    localparam psir_state_t STATE_RST = '{
        build:      psir_pkg::BUILD_ONE,
        riser:      1'h0,
        multi_fn:   6'h00,
        strap_cnt:  2'h0,
        strap_done: 1'h0,
        line_o:     8'h00,
        line_oe:    8'h00,
        level_n:    8'hFF,
        req_n:      5'h1F,
        gnt_n:      5'h1F,
        idsel:      6'h00
    };

    psir_state_t state_reg;
    psir_state_t state_next;

    logic                                rst_sync_b;
    logic [psir_pkg::SYNC_BITS-1:0]      pins_raw;
    logic [psir_pkg::SYNC_BITS-1:0]      pins_sync;
    logic [psir_pkg::SLOTS-1:0][3:0]     int_n_s;
    logic [4:0]                          req_n_s;
    logic [4:0]                          gnt_n_s;
    logic [7:0]                          line_i_s;
    logic [6:0]                          ad_s;
    logic [1:0]                          build_sel_s;
    logic                                riser_s;
    logic [5:0]                          multi_fn_s;

    // ------------------------------------------------------------
    // Reset release and pin synchronisers
    // ------------------------------------------------------------
    psir_sync #(
        .WIDTH   (1),
        .RST_VAL (1'h0)
    ) u_rst_sync (
        .clk    (mclk),
        .arst_b (rst_b),
        .d      (1'h1),
        .q      (rst_sync_b)
    );

    assign pins_raw = {build_sel, riser_fitted, slot_multi_fn, cfg_ad_hi,
                       board_irq_line_h_i, board_irq_line_g_i, board_irq_line_f_i,
                       board_irq_line_e_i, board_irq_line_d_i, board_irq_line_c_i,
                       board_irq_line_b_i, board_irq_line_a_i,
                       arb_gnt_n, slot_req_n,
                       riser_int_n, slot4_int_n, slot3_int_n,
                       slot2_int_n, slot1_int_n, slot0_int_n};

    psir_sync #(
        .WIDTH   (psir_pkg::SYNC_BITS),
        .RST_VAL (psir_pkg::SYNC_RST)
    ) u_pin_sync (
        .clk    (mclk),
        .arst_b (rst_sync_b),
        .d      (pins_raw),
        .q      (pins_sync)
    );

    assign {build_sel_s, riser_s, multi_fn_s, ad_s, line_i_s,
            gnt_n_s, req_n_s, int_n_s} = pins_sync;

    // ------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------
    function automatic psir_pkg::psir_build_t decode_build(input logic [1:0] sel);
        psir_pkg::psir_build_t b;
        b = psir_pkg::BUILD_ONE;
        if (sel == psir_pkg::BUILD_SEL_TWO) begin
            b = psir_pkg::BUILD_TWO;
        end else if (sel == psir_pkg::BUILD_SEL_FIVE) begin
            b = psir_pkg::BUILD_FIVE;
        end
        return b;
    endfunction

    // Fitted slots; the riser top slot only with the riser in slot 0
    function automatic logic [5:0] slots_fitted(input psir_pkg::psir_build_t b,
                                                input logic riser);
        logic [5:0] m;
        m = 6'h00;
        unique case (b)
            psir_pkg::BUILD_ONE:  m = 6'h01;
            psir_pkg::BUILD_TWO:  m = 6'h03;
            // slots 0 to 4 in five-slot build
            psir_pkg::BUILD_FIVE: m = 6'h1F;
            default:              m = 6'h01;
        endcase
        m[5] = riser;
        return m;
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [5:0] fitted;
        logic [7:0] asrt;
        logic [2:0] line;
        logic [2:0] ad_idx;
        fitted = 6'h00;
        asrt = 8'h00;
        line = 3'h0;
        ad_idx = 3'h0;
        state_next = state_reg;

        // Straps caught once, after the synchroniser has filled
        if (!state_reg.strap_done) begin
            if (state_reg.strap_cnt == psir_pkg::STRAP_SETTLE) begin
                state_next.build      = decode_build(build_sel_s);
                state_next.riser      = riser_s;
                state_next.multi_fn   = multi_fn_s;
                state_next.strap_done = 1'h1;
            end else begin
                state_next.strap_cnt = state_reg.strap_cnt + 2'h1;
            end
        end

        // Nothing routed until the build is known
        fitted = state_reg.strap_done ? slots_fitted(state_reg.build, state_reg.riser) : 6'h00;

        for (int s = 0; s < psir_pkg::SLOTS; s++) begin
            for (int p = 0; p < psir_pkg::PINS; p++) begin
                line = psir_pkg::SLOT_ROUTE[s][p];
                // slot 2 lines C, D, B, A
                // slot 3 lines D, C, F, G
                // slot 4 lines F, G, H, E
                if (fitted[s] && (p == 0 || state_reg.multi_fn[s]) && !int_n_s[s][p]) begin
                    asrt[line] = 1'h1;
                end
            end
            ad_idx = 3'(psir_pkg::SLOT_IDSEL_AD[s] - psir_pkg::AD_LOW);
            state_next.idsel[s] = fitted[s] & ad_s[ad_idx];
        end

        for (int k = 0; k < psir_pkg::PAIRS; k++) begin
            state_next.req_n[k] = fitted[k] ? req_n_s[k] : 1'h1;
            state_next.gnt_n[k] = fitted[k] ? gnt_n_s[k] : 1'h1;
        end

        state_next.line_o = 8'h00;
        // held while any routed pin is low
        state_next.line_oe = asrt;
        state_next.level_n = line_i_s;
    end

    always_ff @(posedge mclk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            state_reg <= STATE_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign arb_req_n           = state_reg.req_n;
    assign slot_gnt_n          = state_reg.gnt_n;
    assign slot_idsel          = state_reg.idsel;
    assign board_irq_level_n   = state_reg.level_n;
    assign board_irq_line_a_o  = state_reg.line_o[0];
    assign board_irq_line_b_o  = state_reg.line_o[1];
    assign board_irq_line_c_o  = state_reg.line_o[2];
    assign board_irq_line_d_o  = state_reg.line_o[3];
    assign board_irq_line_e_o  = state_reg.line_o[4];
    assign board_irq_line_f_o  = state_reg.line_o[5];
    assign board_irq_line_g_o  = state_reg.line_o[6];
    assign board_irq_line_h_o  = state_reg.line_o[7];
    assign board_irq_line_a_oe = state_reg.line_oe[0];
    assign board_irq_line_b_oe = state_reg.line_oe[1];
    assign board_irq_line_c_oe = state_reg.line_oe[2];
    assign board_irq_line_d_oe = state_reg.line_oe[3];
    assign board_irq_line_e_oe = state_reg.line_oe[4];
    assign board_irq_line_f_oe = state_reg.line_oe[5];
    assign board_irq_line_g_oe = state_reg.line_oe[6];
    assign board_irq_line_h_oe = state_reg.line_oe[7];
endmodule

/* verification/psir_board_model.sv */
// Board wiring and chipset interrupt controller model
module psir_board_model (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_b,
    // Line drivers, bit 0 is line A
    input  wire logic [7:0] dut_oe,
    input  wire logic [7:0] ext_n,
    // Wire levels and pending requests
    output logic      [7:0] line_lvl,
    output logic      [7:0] pend
);
    timeunit 1ns;
    timeprecision 1ns;
    // pull-up, low if any source pulls
    assign line_lvl = ~dut_oe & ext_n;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pend <= 8'h00;
        end else begin
            pend <= ~line_lvl;
        end
    end
endmodule

/* verification/psir_top_assertions.sv */
// Timing checks on the routing top ports
module psir_top_assertions (
    // Clock and reset
    input wire logic       mclk,
    input wire logic       rst_b,
    // Slot pins
    input wire logic [3:0] slot0_int_n,
    input wire logic [3:0] slot1_int_n,
    input wire logic [3:0] slot2_int_n,
    input wire logic [3:0] slot4_int_n,
    input wire logic [3:0] riser_int_n,
    // Request, grant, select
    input wire logic [4:0] slot_req_n,
    input wire logic [4:0] arb_req_n,
    input wire logic [4:0] arb_gnt_n,
    input wire logic [4:0] slot_gnt_n,
    input wire logic [6:0] cfg_ad_hi,
    input wire logic [5:0] slot_idsel,
    // Board lines
    input wire logic       board_irq_line_a_i,
    input wire logic       board_irq_line_a_o,
    input wire logic       board_irq_line_a_oe,
    input wire logic       board_irq_line_e_oe,
    input wire logic [7:0] board_irq_level_n
);
    default clocking cb @(posedge mclk);
    endclocking
    // Outputs trail inputs by three edges, so checks wait that long after release
    logic [1:0] rel_cnt;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rel_cnt <= 2'h0;
        end else if (rel_cnt != 2'h3) begin
            rel_cnt <= rel_cnt + 2'h1;
        end
    end
    default disable iff (!rst_b || rel_cnt != 2'h3);
    property p_o_a;
        !board_irq_line_a_o;
    endproperty
    a_o_a: assert property (p_o_a) else $error("line A driven high");
    property p_oe_a_rise;
        !slot0_int_n[0] |-> ##3 board_irq_line_a_oe;
    endproperty
    a_oe_a_rise: assert property (p_oe_a_rise) else $error("line A not asserted");
    property p_oe_a_fall;
        slot0_int_n[0] && slot2_int_n[3] |-> ##3 !board_irq_line_a_oe;
    endproperty
    a_oe_a_fall: assert property (p_oe_a_fall) else $error("line A held");
    property p_oe_e_cause;
        board_irq_line_e_oe |-> !$past(slot1_int_n[0], 3) || !$past(slot4_int_n[3], 3)
            || !$past(riser_int_n[3], 3);
    endproperty
    a_oe_e_cause: assert property (p_oe_e_cause) else $error("line E without source");
    property p_req0;
        arb_req_n[0] == $past(slot_req_n[0], 3);
    endproperty
    a_req0: assert property (p_req0) else $error("request 0 wrong");
    property p_gnt0;
        slot_gnt_n[0] == $past(arb_gnt_n[0], 3);
    endproperty
    a_gnt0: assert property (p_gnt0) else $error("grant 0 wrong");
    property p_idsel0;
        slot_idsel[0] == $past(cfg_ad_hi[0], 3);
    endproperty
    a_idsel0: assert property (p_idsel0) else $error("select 0 wrong");
    property p_idsel5;
        slot_idsel[5] |-> $past(cfg_ad_hi[6], 3);
    endproperty
    a_idsel5: assert property (p_idsel5) else $error("riser select wrong");
    property p_level_a;
        board_irq_level_n[0] == $past(board_irq_line_a_i, 3);
    endproperty
    a_level_a: assert property (p_level_a) else $error("line A readback wrong");
    c_shared: cover property (!slot0_int_n[0] && !slot2_int_n[3]);
    c_idsel5: cover property (slot_idsel[5]);
    c_oe_e: cover property (board_irq_line_e_oe);
endmodule
bind psir_top psir_top_assertions chk_u (.mclk(mclk), .rst_b(rst_b),
    .slot0_int_n(slot0_int_n), .slot1_int_n(slot1_int_n), .slot2_int_n(slot2_int_n),
    .slot4_int_n(slot4_int_n), .riser_int_n(riser_int_n), .slot_req_n(slot_req_n),
    .arb_req_n(arb_req_n), .arb_gnt_n(arb_gnt_n), .slot_gnt_n(slot_gnt_n),
    .cfg_ad_hi(cfg_ad_hi), .slot_idsel(slot_idsel), .board_irq_line_a_i(board_irq_line_a_i),
    .board_irq_line_a_o(board_irq_line_a_o), .board_irq_line_a_oe(board_irq_line_a_oe),
    .board_irq_line_e_oe(board_irq_line_e_oe), .board_irq_level_n(board_irq_level_n));

/* verification/tb_top.sv */
// Testbench for slot interrupt and select routing
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic            mclk, rst_b, riser_fitted;
    logic [1:0]      build_sel;
    logic [5:0]      multi_fn, idsel;
    logic [5:0][3:0] pin_n;
    logic [4:0]      req_n, gnt_n, arb_req_n, slot_gnt_n;
    logic [6:0]      ad;
    logic [7:0]      ext_n, oe_v, o_v, lvl, level_n, pend;
    int              mismatches, compares;
    // Expected line per slot and pin, A is 0
    int route [6][4] = '{'{0, 1, 2, 3}, '{4, 5, 6, 7}, '{2, 3, 1, 0}, '{3, 2, 5, 6},
                         '{5, 6, 7, 4}, '{5, 6, 7, 4}};
    psir_top dut_u (.mclk(mclk), .rst_b(rst_b), .build_sel(build_sel),
        .riser_fitted(riser_fitted), .slot_multi_fn(multi_fn), .slot0_int_n(pin_n[0]),
        .slot1_int_n(pin_n[1]), .slot2_int_n(pin_n[2]), .slot3_int_n(pin_n[3]),
        .slot4_int_n(pin_n[4]), .riser_int_n(pin_n[5]), .slot_req_n(req_n),
        .arb_req_n(arb_req_n), .arb_gnt_n(gnt_n), .slot_gnt_n(slot_gnt_n), .cfg_ad_hi(ad),
        .slot_idsel(idsel), .board_irq_level_n(level_n),
        .board_irq_line_a_i(lvl[0]), .board_irq_line_a_o(o_v[0]), .board_irq_line_a_oe(oe_v[0]),
        .board_irq_line_b_i(lvl[1]), .board_irq_line_b_o(o_v[1]), .board_irq_line_b_oe(oe_v[1]),
        .board_irq_line_c_i(lvl[2]), .board_irq_line_c_o(o_v[2]), .board_irq_line_c_oe(oe_v[2]),
        .board_irq_line_d_i(lvl[3]), .board_irq_line_d_o(o_v[3]), .board_irq_line_d_oe(oe_v[3]),
        .board_irq_line_e_i(lvl[4]), .board_irq_line_e_o(o_v[4]), .board_irq_line_e_oe(oe_v[4]),
        .board_irq_line_f_i(lvl[5]), .board_irq_line_f_o(o_v[5]), .board_irq_line_f_oe(oe_v[5]),
        .board_irq_line_g_i(lvl[6]), .board_irq_line_g_o(o_v[6]), .board_irq_line_g_oe(oe_v[6]),
        .board_irq_line_h_i(lvl[7]), .board_irq_line_h_o(o_v[7]), .board_irq_line_h_oe(oe_v[7]));
    psir_board_model brd_u (.mclk(mclk), .rst_b(rst_b), .dut_oe(oe_v), .ext_n(ext_n),
        .line_lvl(lvl), .pend(pend));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // Straps are caught once, so each build needs a reset
    task automatic start(input logic [1:0] bs, input logic rf, input logic [5:0] mf);
        @(posedge mclk);
        rst_b <= 1'b0;
        build_sel <= bs;
        riser_fitted <= rf;
        multi_fn <= mf;
        pin_n <= '1;
        req_n <= '1;
        gnt_n <= '1;
        ad <= '0;
        ext_n <= '1;
        repeat (3) @(posedge mclk);
        rst_b <= 1'b1;
        tick(12);
    endtask
    // Seven edges cover oe and the readback path
    task automatic pins(input int s, input int p, input logic v);
        @(posedge mclk);
        pin_n[s][p] <= v;
        tick(7);
    endtask
    task automatic t_routes_five;
        logic [7:0] e;
        start(2'h2, 1'b1, 6'h3F);
        for (int s = 0; s < 6; s++) begin
            for (int p = 0; p < 4; p++) begin
                e = 8'h01 << route[s][p];
                pins(s, p, 1'b0);
                cmp8(oe_v, e);
                cmp8(level_n, ~e);
                cmp8(o_v, 8'h00);
                pins(s, p, 1'b1);
                cmp8(oe_v, 8'h00);
            end
        end
        for (int k = 0; k < 7; k++) begin
            @(posedge mclk);
            ad <= 7'h01 << k;
            tick(4);
            e = (k < 5) ? 8'h01 << k : (k == 6) ? 8'h20 : 8'h00;
            cmp8({2'h0, idsel}, e);
        end
        for (int k = 0; k < 5; k++) begin
            @(posedge mclk);
            req_n <= ~(5'h01 << k);
            gnt_n <= ~(5'h01 << k);
            tick(4);
            cmp8({3'h7, arb_req_n}, ~(8'h01 << k));
            cmp8({3'h7, slot_gnt_n}, ~(8'h01 << k));
        end
    endtask
    task automatic t_shared;
        start(2'h2, 1'b0, 6'h3F);
        pins(0, 0, 1'b0);
        pins(2, 3, 1'b0);
        cmp8(oe_v, 8'h01);
        cmp8(pend, 8'h01);
        pins(0, 0, 1'b1);
        cmp8(oe_v, 8'h01);
        pins(2, 3, 1'b1);
        cmp8(oe_v, 8'h00);
        cmp8(pend, 8'h00);
        @(posedge mclk);
        ext_n <= 8'hFE;
        tick(7);
        cmp8(level_n, 8'hFE);
        cmp8(oe_v, 8'h00);
    endtask
    task automatic t_single(input logic [1:0] bs);
        start(bs, 1'b0, 6'h00);
        @(posedge mclk);
        pin_n <= 24'h000001;
        tick(7);
        cmp8(oe_v, 8'h00);
        @(posedge mclk);
        pin_n[0][0] <= 1'b0;
        req_n <= '0;
        gnt_n <= '0;
        ad <= 7'h7F;
        tick(7);
        cmp8(oe_v, 8'h01);
        cmp8({2'h0, idsel}, 8'h01);
        cmp8({3'h7, arb_req_n}, 8'hFE);
        cmp8({3'h7, slot_gnt_n}, 8'hFE);
    endtask
    task automatic t_two;
        start(2'h1, 1'b0, 6'h3F);
        @(posedge mclk);
        pin_n <= 24'h0000FF;
        req_n <= '0;
        ad <= 7'h7F;
        tick(7);
        cmp8(oe_v, 8'h00);
        cmp8({2'h0, idsel}, 8'h03);
        cmp8({3'h7, arb_req_n}, 8'hFC);
        @(posedge mclk);
        pin_n <= 24'h00000F;
        tick(7);
        cmp8(oe_v, 8'hF0);
    endtask
    task automatic results;
        $display("mismatches=%0d compares=%0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        #100000;
        mismatches++;
        results;
    end
    initial begin
        mismatches = 0;
        compares = 0;
        rst_b = 1'b0;
        build_sel = 2'h0;
        riser_fitted = 1'b0;
        multi_fn = 6'h00;
        pin_n = '1;
        req_n = '1;
        gnt_n = '1;
        ad = '0;
        ext_n = '1;
        t_routes_five;
        t_shared;
        t_single(2'h0);
        t_single(2'h3);
        t_two;
        results;
    end
endmodule
